// ### design/wdtw_pkg.sv
// Constants and types shared by the windowed watchdog timer
package wdtw_pkg;
   // System clock and nominal watchdog oscillator rate
   localparam int unsigned CLK_FREQ_HZ = 25_000_000;
   localparam int unsigned OSC_FREQ_HZ = 32_000;
   // Clock cycles per oscillator tick, rounded down
   localparam int unsigned OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
   // Base time-outs at postscale 1:1, in microseconds
   localparam int unsigned BASE_SHORT_US = 1000;
   localparam int unsigned BASE_LONG_US = 4000;
   // Prescaler ratios derived from the base time-outs (32 and 128)
   localparam int unsigned PRE_SHORT = BASE_SHORT_US * OSC_FREQ_HZ
      / 1_000_000;
   localparam int unsigned PRE_LONG = BASE_LONG_US * OSC_FREQ_HZ
      / 1_000_000;
   // Tick counter width: 128 * 32768 ticks needs 23 bits
   localparam int CNT_W = 23;
   localparam int DIV_W = 16;
   // Register byte addresses
   localparam logic [11:0] ADDR_CONFIG = 12'h000;
   localparam logic [11:0] ADDR_RST_CTRL = 12'h004;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
   localparam logic [11:0] ADDR_COUNT = 12'h010;
   localparam logic [11:0] ADDR_PERIOD = 12'h014;
   // Reset control register bit positions
   localparam int CTRL_IDLE = 2;
   localparam int CTRL_SLEEP = 3;
   localparam int CTRL_TIMEOUT = 4;
   localparam int CTRL_SW_EN = 5;
   // Interrupt status bit positions
   localparam int IRQ_W = 3;
   localparam int IRQ_TIMEOUT = 0;
   localparam int IRQ_WINDOW = 1;
   localparam int IRQ_WAKE = 2;
   // Reset values
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
   // Fuse word layout, bit 7 down to bit 0
   typedef struct packed {
      logic hw_enable_fuse;     // Bit 7
      logic window_disable_bit; // Bit 6
      logic reserved;           // Bit 5
      logic prescale_select;    // Bit 4, 1 selects divide by 128
      logic [3:0] postscale_select; // Bits 3:0
   } wdtw_cfg_t;
   // Power mode, Gray coded from run to either save mode
   typedef enum logic [1:0] {
      WDTW_RUN = 2'h0,
      WDTW_SLEEP = 2'h1,
      WDTW_IDLE = 2'h2
   } wdtw_pmode_t;
endpackage : wdtw_pkg

// ### design/wdtw_top.sv
// Windowed watchdog timer with APB registers and interrupt
// Functional notes
// - Counts oscillator ticks; enabling powers the oscillator
// - Prescale select picks divide by 32 or 128
// - Base period 1 ms or 4 ms
// - Four-bit postscale, sixteen ratios up to 32768
// - Any device reset clears all counts
// - Completed clock switch clears all counts
// - Entering sleep or idle clears all counts
// - Leaving sleep or idle clears all counts
// - Clear instruction in run clears all counts
// - Runs in sleep/idle; time-out wakes the core
// - Sticky time-out flag, cleared by software or any device reset
// - Hardware fuse forces the watchdog on
// - Without fuse, software enable bit controls it
// - Software enable bit cleared by every reset
// - Early clear in windowed mode resets device
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module wdtw_top #(
   parameter int unsigned OSC_DIV = wdtw_pkg::OSC_DIV,
   parameter int CNT_W = wdtw_pkg::CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fuse word
   input wire wdtw_pkg::wdtw_cfg_t watchdog_config_word,
   // Core events, one-cycle pulses
   input wire logic watchdog_clear_instr,
   input wire logic power_save_sleep_instr,
   input wire logic power_save_idle_instr,
   input wire logic clock_switch_done,
   input wire logic power_save_exit,
   // Results
   output logic low_power_rc_clock_on,
   output logic watchdog_reset,
   output logic wake_request,
   output logic irq
);
   // Control and status state
   logic sw_enable_bit;  // Software enable
   logic timeout_flag;   // Sticky time-out flag
   logic sleep_flag;     // Entered sleep
   logic idle_flag;      // Entered idle
   logic [wdtw_pkg::IRQ_W-1:0] irq_status; // Sticky events
   logic [wdtw_pkg::IRQ_W-1:0] irq_mask;   // Enables
   wdtw_pkg::wdtw_pmode_t pmode;           // Power mode
   logic [wdtw_pkg::DIV_W-1:0] div_cnt;    // Oscillator model
   logic osc_tick;                         // One tick pulse
   logic [CNT_W-1:0] count;                // Combined pre/post count
   logic [31:0] next_prdata;               // Read mux
   // Derived terms
   logic wdt_enable;
   logic in_run;
   logic [CNT_W-1:0] base;
   logic [CNT_W-1:0] period;
   logic window_open, timeout, window_bad; // Watchdog decisions
   logic enter_save, leave_save, count_clear; // Mode and clear terms
   logic reg_write, addr_ok; // Bus decode
   logic [wdtw_pkg::IRQ_W-1:0] irq_event;

   // Fuse wins over software enable
   assign wdt_enable = watchdog_config_word.hw_enable_fuse
      | sw_enable_bit;
   assign in_run = (pmode == wdtw_pkg::WDTW_RUN);
   // Prescaler ratio, then postscaler shift
   assign base = watchdog_config_word.prescale_select
      ? CNT_W'(wdtw_pkg::PRE_LONG)
      : CNT_W'(wdtw_pkg::PRE_SHORT);
   assign period = base
      << watchdog_config_word.postscale_select;
   // Final quarter starts at three quarters of the period
   assign window_open = count >= (period - (period >> 2));
   assign timeout = wdt_enable && osc_tick
      && (count == period - CNT_W'(1));
   assign enter_save = in_run
      && (power_save_sleep_instr || power_save_idle_instr);
   assign leave_save = !in_run && (timeout || power_save_exit);
   // Early clear only matters when the window is armed
   assign window_bad = in_run && wdt_enable && watchdog_clear_instr
      && !watchdog_config_word.window_disable_bit
      && !window_open;
   // Every documented clearing event, plus disable
   assign count_clear = clock_switch_done
      || enter_save
      || leave_save
      || (in_run && watchdog_clear_instr)
      || !wdt_enable;
   assign irq_event = {leave_save && timeout, window_bad,
      timeout && in_run};
   // Write lands only in the completing access cycle
   assign reg_write = psel && penable && pready && pwrite;
   assign addr_ok = (paddr <= wdtw_pkg::ADDR_PERIOD)
      && (paddr[1:0] == 2'h0); // Six aligned words from zero

   // Oscillator power follows the enable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         low_power_rc_clock_on <= 1'b0;
      end else begin
         low_power_rc_clock_on <= wdt_enable;
      end
   end

   // Oscillator tick model; held at zero while powered off
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= '0;
         osc_tick <= 1'b0;
      end else if (!low_power_rc_clock_on) begin
         div_cnt <= '0;
         osc_tick <= 1'b0;
      end else if (div_cnt == wdtw_pkg::DIV_W'(OSC_DIV - 1)) begin
         div_cnt <= '0;
         osc_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + wdtw_pkg::DIV_W'(1);
         osc_tick <= 1'b0;
      end
   end

   // Watchdog count; keeps running in sleep and idle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
      end else if (count_clear || timeout) begin
         count <= '0;
      end else if (osc_tick) begin
         count <= count + CNT_W'(1);
      end
   end

   // Power mode tracking
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pmode <= wdtw_pkg::WDTW_RUN;
      end else begin
         unique case (pmode)
            wdtw_pkg::WDTW_RUN: begin
               // Sleep takes priority if both pulse together
               if (power_save_sleep_instr) begin
                  pmode <= wdtw_pkg::WDTW_SLEEP;
               end else if (power_save_idle_instr) begin
                  pmode <= wdtw_pkg::WDTW_IDLE;
               end
            end
            wdtw_pkg::WDTW_SLEEP, wdtw_pkg::WDTW_IDLE: begin
               // Wake resumes after the save instruction
               if (leave_save) begin
                  pmode <= wdtw_pkg::WDTW_RUN;
               end
            end
            default: begin
               pmode <= wdtw_pkg::WDTW_RUN;
            end
         endcase
      end
   end

   // Reset and wake pulses
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         watchdog_reset <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         watchdog_reset <= (timeout && in_run)
            || window_bad;
         wake_request <= timeout && !in_run;
      end
   end

   // Software enable bit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_enable_bit <= 1'b0;
      end else if (reg_write && paddr == wdtw_pkg::ADDR_RST_CTRL) begin
         sw_enable_bit <= pwdata[wdtw_pkg::CTRL_SW_EN];
      end
   end

   // Status flags: writing zero clears, a new event wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timeout_flag <= 1'b0;
         sleep_flag <= 1'b0;
         idle_flag <= 1'b0;
      end else begin
         if (timeout || window_bad) begin
            timeout_flag <= 1'b1;
         end else if (reg_write && paddr == wdtw_pkg::ADDR_RST_CTRL) begin
            timeout_flag <= pwdata[wdtw_pkg::CTRL_TIMEOUT];
         end
         if (enter_save && power_save_sleep_instr) begin
            sleep_flag <= 1'b1;
         end else if (reg_write && paddr == wdtw_pkg::ADDR_RST_CTRL) begin
            sleep_flag <= pwdata[wdtw_pkg::CTRL_SLEEP];
         end
         if (enter_save && !power_save_sleep_instr) begin
            idle_flag <= 1'b1;
         end else if (reg_write && paddr == wdtw_pkg::ADDR_RST_CTRL) begin
            idle_flag <= pwdata[wdtw_pkg::CTRL_IDLE];
         end
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_status <= '0;
      end else if (reg_write && paddr == wdtw_pkg::ADDR_IRQ_STATUS) begin
         irq_status <= (irq_status & ~pwdata[wdtw_pkg::IRQ_W-1:0])
            | irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end

   // Interrupt mask and output level
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask <= wdtw_pkg::IRQ_MASK_RESET;
         irq <= 1'b0;
      end else begin
         if (reg_write && paddr == wdtw_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= pwdata[wdtw_pkg::IRQ_W-1:0];
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // Read mux; reserved bits read as zero, except fuse word bit 5
   always_comb begin
      next_prdata = '0;
      unique case (paddr)
         wdtw_pkg::ADDR_CONFIG: next_prdata[7:0] = watchdog_config_word;
         wdtw_pkg::ADDR_RST_CTRL: begin
            next_prdata[wdtw_pkg::CTRL_IDLE] = idle_flag;
            next_prdata[wdtw_pkg::CTRL_SLEEP] = sleep_flag;
            next_prdata[wdtw_pkg::CTRL_TIMEOUT] = timeout_flag;
            next_prdata[wdtw_pkg::CTRL_SW_EN] = sw_enable_bit;
         end
         wdtw_pkg::ADDR_IRQ_STATUS:
            next_prdata[wdtw_pkg::IRQ_W-1:0] = irq_status;
         wdtw_pkg::ADDR_IRQ_MASK:
            next_prdata[wdtw_pkg::IRQ_W-1:0] = irq_mask;
         wdtw_pkg::ADDR_COUNT: next_prdata[CNT_W-1:0] = count;
         wdtw_pkg::ADDR_PERIOD: next_prdata[CNT_W-1:0] = period;
         default: next_prdata = '0;
      endcase
   end

   // APB answer: one access cycle, data sampled in setup
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable) begin
            prdata <= next_prdata;
         end
      end
   end

   // Checks
   property p_osc_on;
      @(posedge clk) disable iff (!rst_b)
      rst_b && wdt_enable |=> low_power_rc_clock_on; // Not at release
   endproperty
   a_osc_on: assert property (p_osc_on)
      else $error("oscillator not powered while enabled");

   property p_base;
      @(posedge clk) disable iff (!rst_b)
      watchdog_config_word.postscale_select == 4'h0
      |-> period == (watchdog_config_word.prescale_select
      ? 23'h000080 : 23'h000020);
   endproperty
   a_base: assert property (p_base)
      else $error("base period wrong");

   property p_post_max;
      @(posedge clk) disable iff (!rst_b)
      watchdog_config_word.postscale_select == 4'hF
      && !watchdog_config_word.prescale_select
      |-> period == 23'h100000;
   endproperty
   a_post_max: assert property (p_post_max)
      else $error("postscale 1:32768 wrong");

   property p_clr_switch;
      @(posedge clk) disable iff (!rst_b)
      clock_switch_done |=> count == '0;
   endproperty
   a_clr_switch: assert property (p_clr_switch)
      else $error("clock switch did not clear count");

   property p_clr_enter;
      @(posedge clk) disable iff (!rst_b)
      in_run && power_save_sleep_instr
      |=> count == '0 && pmode == wdtw_pkg::WDTW_SLEEP;
   endproperty
   a_clr_enter: assert property (p_clr_enter)
      else $error("sleep entry did not clear count");

   property p_clr_exit;
      @(posedge clk) disable iff (!rst_b)
      !in_run && power_save_exit |=> count == '0 && in_run;
   endproperty
   a_clr_exit: assert property (p_clr_exit)
      else $error("exit did not clear count");

   property p_clr_instr;
      @(posedge clk) disable iff (!rst_b)
      in_run && watchdog_clear_instr |=> count == '0;
   endproperty
   a_clr_instr: assert property (p_clr_instr)
      else $error("clear instruction did not clear count");

   property p_wake;
      @(posedge clk) disable iff (!rst_b)
      timeout && !in_run
      |=> wake_request && in_run && !watchdog_reset;
   endproperty
   a_wake: assert property (p_wake)
      else $error("time-out in save mode did not wake");

   property p_sticky;
      @(posedge clk) disable iff (!rst_b)
      timeout_flag && !(reg_write && paddr == wdtw_pkg::ADDR_RST_CTRL)
      |=> timeout_flag;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("time-out flag dropped by itself");

   property p_fuse;
      @(posedge clk) disable iff (!rst_b)
      (rst_b && watchdog_config_word.hw_enable_fuse) [*2]
      |-> low_power_rc_clock_on;
   endproperty
   a_fuse: assert property (p_fuse)
      else $error("fuse did not force watchdog on");

   property p_window;
      @(posedge clk) disable iff (!rst_b)
      window_bad |=> watchdog_reset && timeout_flag && count == '0;
   endproperty
   a_window: assert property (p_window)
      else $error("early clear did not reset");

   property p_run_reset;
      @(posedge clk) disable iff (!rst_b)
      timeout && in_run |=> watchdog_reset && timeout_flag;
   endproperty
   a_run_reset: assert property (p_run_reset)
      else $error("run time-out did not reset");
endmodule : wdtw_top

// ### sim/wdtw_top_tb.sv
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/100ps
module wdtw_top_tb;
   // Short oscillator divide keeps every measured period to at most 1024 cycles
   localparam int DIV = 4;
   // Slack for tick phase and bus latency around a measured period
   localparam int TOL = 2 * DIV + 4;
   // Clock, reset and APB
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // Fuse word and event pulses: clear, sleep, idle, switch, exit
   wdtw_pkg::wdtw_cfg_t cfg = 8'h40;
   logic [4:0] ev = 5'h00;
   // Results
   logic osc_on;
   logic wdt_rst;
   logic wake;
   logic irq;
   // Bookkeeping
   int mismatches = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic err;

   // Free-running system clock
   always #20 clk = ~clk;

   // Device under test
   wdtw_top #(.OSC_DIV(DIV), .CNT_W(wdtw_pkg::CNT_W)) uut (
      .clk(clk), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .watchdog_config_word(cfg),
      .watchdog_clear_instr(ev[0]), .power_save_sleep_instr(ev[1]),
      .power_save_idle_instr(ev[2]), .clock_switch_done(ev[3]),
      .power_save_exit(ev[4]), .low_power_rc_clock_on(osc_on),
      .watchdog_reset(wdt_rst), .wake_request(wake), .irq(irq)
   );

   // Verdict and end of run
   task finish_test;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test

   // Compare seen against expected
   task check(input string name, input logic [31:0] seen,
              input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One APB transfer; request held until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         finish_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // One-cycle event pulse
   task pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask : pulse

   // Run n cycles and expect no watchdog reset
   task quiet(input int n, input string name);
      int seen;
      seen = 0;
      repeat (n) begin
         @(posedge clk);
         if (wdt_rst === 1'b1) seen++;
      end
      check(name, seen, 0);
   endtask : quiet

   // Wait for reset or wake; check which one and after how long
   task timed(input int expc, input logic want_wake, input string name);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wdt_rst !== 1'b1 && wake !== 1'b1 && n < 3 * expc + 20);
      check({name, " wake"}, wake, want_wake);
      check({name, " reset"}, wdt_rst, !want_wake);
      check({name, " time"}, n >= expc - TOL && n <= expc + TOL, 1);
      if (n >= 3 * expc + 20) begin
         mismatches++;
         finish_test;
      end
   endtask : timed

   // Reset held ten cycles, fuse word changed while held
   task do_reset(input logic [7:0] c);
      @(posedge clk);
      rst_b <= 1'b0;
      cfg <= c;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
   endtask : do_reset

   // Main sequence
   initial begin
      do_reset(8'h40);
      apb(0, wdtw_pkg::ADDR_RST_CTRL, 0);
      check("ctrl reset", rd, 0);
      apb(0, wdtw_pkg::ADDR_IRQ_MASK, 0);
      check("mask reset", rd, 0);
      apb(0, wdtw_pkg::ADDR_COUNT, 0);
      check("count reset", rd, 0);
      check("osc off", osc_on, 0);
      apb(0, wdtw_pkg::ADDR_CONFIG, 0);
      check("config", rd, 32'h0000_0040);
      apb(0, 12'h0FC, 0);
      check("unmapped err", err, 1);
      check("unmapped data", rd, 0);
      // Every prescale and postscale setting
      for (int p = 0; p < 2; p++) begin
         for (int s = 0; s < 16; s++) begin
            do_reset({3'b010, p[0], s[3:0]});
            apb(0, wdtw_pkg::ADDR_PERIOD, 0);
            check("period", rd, (p ? 128 : 32) << s);
         end
      end
      // Measured periods from a clock switch, postscale 1:2
      for (int p = 0; p < 2; p++) begin
         do_reset({3'b010, p[0], 4'h1});
         apb(1, wdtw_pkg::ADDR_RST_CTRL, 32'h20);
         repeat (2) @(posedge clk);
         check("osc on", osc_on, 1);
         pulse(3);
         timed((p ? 256 : 64) * DIV, 0, "run");
         apb(0, wdtw_pkg::ADDR_RST_CTRL, 0);
         check("flag set", rd, 32'h30);
      end
      // Interrupt masked, unmasked, cleared
      apb(0, wdtw_pkg::ADDR_IRQ_STATUS, 0);
      check("status", rd, 32'h1);
      check("irq masked", irq, 0);
      apb(1, wdtw_pkg::ADDR_IRQ_MASK, 32'h7);
      repeat (2) @(posedge clk);
      check("irq on", irq, 1);
      apb(1, wdtw_pkg::ADDR_RST_CTRL, 0);
      apb(1, wdtw_pkg::ADDR_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      check("irq off", irq, 0);
      apb(0, wdtw_pkg::ADDR_IRQ_STATUS, 0);
      check("status w1c", rd, 0);
      apb(0, wdtw_pkg::ADDR_RST_CTRL, 0);
      check("flag cleared", rd, 0);
      apb(0, wdtw_pkg::ADDR_COUNT, 0);
      check("disabled count", rd, 0);
      check("disabled osc", osc_on, 0);
      // Clear instruction and clock switch keep it alive
      do_reset(8'h40);
      apb(1, wdtw_pkg::ADDR_RST_CTRL, 32'h20);
      repeat (3) begin
         quiet(80, "clear alive");
         pulse(0);
      end
      apb(0, wdtw_pkg::ADDR_COUNT, 0);
      check("count cleared", rd <= 2, 1);
      repeat (3) begin
         quiet(80, "switch alive");
         pulse(3);
      end
      // Sleep then idle: counting goes on and the time-out wakes
      for (int m = 0; m < 2; m++) begin
         pulse(1 + m);
         apb(0, wdtw_pkg::ADDR_RST_CTRL, 0);
         check("save flag", rd, m ? 32'h24 : 32'h28);
         timed(32 * DIV, 1, "save");
         pulse(4);
         apb(1, wdtw_pkg::ADDR_RST_CTRL, 32'h20);
         apb(0, wdtw_pkg::ADDR_RST_CTRL, 0);
         check("save flags off", rd, 32'h20);
      end
      // Leaving sleep restarts the full period
      pulse(1);
      quiet(90, "asleep");
      pulse(4);
      timed(32 * DIV, 0, "exit");
      // Windowed mode: early clear resets, late clear is accepted
      do_reset(8'h00);
      apb(1, wdtw_pkg::ADDR_RST_CTRL, 32'h20);
      pulse(3);
      quiet(20, "before early");
      pulse(0);
      timed(2, 0, "early clear");
      apb(0, wdtw_pkg::ADDR_IRQ_STATUS, 0);
      check("window status", rd, 32'h2);
      pulse(3);
      quiet(110, "before late");
      pulse(0);
      quiet(20, "late clear");
      // Reset in mid-run clears count and software enable
      do_reset(8'h40);
      apb(0, wdtw_pkg::ADDR_RST_CTRL, 0);
      check("ctrl rerun", rd, 0);
      apb(0, wdtw_pkg::ADDR_COUNT, 0);
      check("count rerun", rd, 0);
      // Fuse forces it on whatever the software bit says
      do_reset(8'hC0);
      repeat (2) @(posedge clk);
      check("fuse osc", osc_on, 1);
      apb(1, wdtw_pkg::ADDR_RST_CTRL, 0);
      pulse(3);
      timed(32 * DIV, 0, "fuse");
      finish_test;
   end

   // Hang guard
   initial begin
      #2_000_000;
      mismatches++;
      finish_test;
   end
endmodule : wdtw_top_tb
